/* hdl/wdg_pkg.sv */
// Purpose: Shared constants and types for the key-unlocked independent watchdog.
// Assumes: Register data is 8 bits wide, carried in the low bits of a 32-bit APB word.
// Notes:   Register offsets are word indexes; the byte address is four times the index.

package wdg_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = ADDR_W - 2;

   // ---------------------------------------------------------------
   // Register indexes
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_KEY_COMMAND = 6'h00;
   localparam logic [IDX_W-1:0] IDX_PRESCALE_SELECT = 6'h01;
   localparam logic [IDX_W-1:0] IDX_RELOAD_VALUE = 6'h02;
   localparam logic [IDX_W-1:0] IDX_STATUS = 6'h03;

   // ---------------------------------------------------------------
   // Key codes
   // ---------------------------------------------------------------
   localparam logic [7:0] KEY_START = 8'hCC;
   localparam logic [7:0] KEY_REFRESH = 8'hAA;
   localparam logic [7:0] KEY_UNLOCK = 8'h55;

   // ---------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------
   localparam int PRESCALE_W = 3;
   localparam int RELOAD_W = 8;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 3'h0;
   localparam logic [RELOAD_W-1:0] RELOAD_RST = 8'hFF;
   localparam logic [RELOAD_W-1:0] COUNT_START = 8'hFF;
   localparam logic [RELOAD_W-1:0] COUNT_END = 8'h00;
   localparam logic [PRESCALE_W-1:0] PRESCALE_MAX = 3'h6;
   localparam int STAT_RUNNING = 0;
   localparam int STAT_UNLOCKED = 1;
   localparam int STAT_BUSY = 2;
   localparam int STAT_EXPIRED = 3;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int LSI_HZ = 128000;
   localparam int BASE_HZ = 64000;
   // Each prescale code step doubles the divider, starting at /4 of the base clock.
   localparam int BASE_DIV_LOG2 = $clog2(LSI_HZ / BASE_HZ);
   localparam int PRE_SHIFT_MIN = BASE_DIV_LOG2 + 2;
   localparam int PRE_W = PRE_SHIFT_MIN + 6;
   localparam logic [PRE_W-1:0] PRE_ONE = 9'h001;
   localparam logic [PRE_W-1:0] PRE_ZERO = 9'h000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_CONFIG = 2'h0,
      CMD_START = 2'h1,
      CMD_REFRESH = 2'h2
   } cmd_type;

   typedef enum logic [1:0] {
      WD_IDLE = 2'h0,
      WD_RUNNING = 2'h1,
      WD_EXPIRED = 2'h3
   } wd_state_type;

endpackage

/* hdl/bit_sync.sv */
// Purpose: Two-flip-flop synchroniser for single-bit levels and toggles.
// Assumes: The input is a level or toggle that stays stable for several destination cycles.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/1ps

module bit_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);

   typedef struct packed {
      logic meta;
      logic sync;
   } sync_state_type;

   sync_state_type sync_q;
   sync_state_type sync_d;

   // The first stage may go metastable, so nothing but the second stage reads it.
   always_comb begin
      sync_d.meta = async_in;
      sync_d.sync = sync_q.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_q.meta <= RST_VAL;
         sync_q.sync <= RST_VAL;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q.sync;

endmodule

/* hdl/key_unlocked_independent_watchdog.sv */
// Purpose: Independent watchdog with key register, locked prescale and reload registers.
// Assumes: APB slave on ref_clk; the down-counter runs on the low-speed internal oscillator.
// Notes:   Register writes cross into the oscillator domain through a toggle handshake.
//
// How it works
// (RULE1) Start key starts counting from 0xFF.
// (RULE2) Count at zero raises watchdog reset.
// (RULE3) Refresh key reloads counter from reload value.
// (RULE4) Prescale and reload writable only after unlock.
// (RULE5) Refresh key relocks configuration and refreshes.
// (RULE6) Auto-start option runs watchdog from power-on.
// (RULE7) Prescale code picks /4 to /256.
// (RULE8) Tick timing from 64 kHz base clock.
// (RULE9) Counter path clocked only by slow oscillator.
// (RULE10) Software writes start key first.
// (RULE11) Software refreshes before count runs out.
// (RULE12) Software keeps prescale upper bits zero.
// (RULE13) Other keys ignored; writes cross domains safely.

`timescale 1ns/1ps

module key_unlocked_independent_watchdog (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic low_speed_internal_osc,
   input wire logic hw_autostart_option,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
   input wire logic [wdg_pkg::DATA_W-1:0] pwdata,
   output logic [wdg_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic watchdog_reset_out
);

   import wdg_pkg::*;

   // ---------------------------------------------------------------
   // State records of the two domains
   // ---------------------------------------------------------------
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
      logic unlocked;
      logic req_tgl;
      cmd_type req_cmd;
      logic [PRESCALE_W-1:0] prescale;
      logic [RELOAD_W-1:0] reload;
   } bus_state_type;

   typedef struct packed {
      wd_state_type st;
      logic ack_tgl;
      logic strap_done;
      logic [PRE_W-1:0] pre_cnt;
      logic [RELOAD_W-1:0] count;
      logic [PRESCALE_W-1:0] prescale;
      logic [RELOAD_W-1:0] reload;
      logic wdg_rst;
   } osc_state_type;

   bus_state_type bus_q;
   bus_state_type bus_d;
   osc_state_type osc_q;
   osc_state_type osc_d;

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   logic osc_rst_n;
   logic req_sync;
   logic ack_sync;
   logic running_sync;
   logic expired_sync;
   logic osc_running;
   logic osc_expired;

   assign osc_running = (osc_q.st == WD_RUNNING);
   assign osc_expired = (osc_q.st == WD_EXPIRED);

   // The oscillator domain sees its own copy of the system reset.
   bit_sync #(
      .RST_VAL(1'b0)
   ) u_rst_sync (
      .clk(low_speed_internal_osc),
      .rst_n(1'b1),
      .async_in(reset_n),
      .sync_out(osc_rst_n)
   );

   bit_sync #(
      .RST_VAL(1'b0)
   ) u_req_sync (
      .clk(low_speed_internal_osc),
      .rst_n(osc_rst_n),
      .async_in(bus_q.req_tgl),
      .sync_out(req_sync)
   ); // [RULE13]

   bit_sync #(
      .RST_VAL(1'b0)
   ) u_ack_sync (
      .clk(ref_clk),
      .rst_n(reset_n),
      .async_in(osc_q.ack_tgl),
      .sync_out(ack_sync)
   ); // [RULE13]

   bit_sync #(
      .RST_VAL(1'b0)
   ) u_run_sync (
      .clk(ref_clk),
      .rst_n(reset_n),
      .async_in(osc_running),
      .sync_out(running_sync)
   );

   bit_sync #(
      .RST_VAL(1'b0)
   ) u_exp_sync (
      .clk(ref_clk),
      .rst_n(reset_n),
      .async_in(osc_expired),
      .sync_out(expired_sync)
   );

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic [IDX_W-1:0] idx;
   logic aligned;
   logic mapped;
   logic busy;
   logic [7:0] wbyte;
   logic key_wr_req;
   logic cfg_wr;
   logic needs_req;
   logic access;
   logic accept;
   logic [DATA_W-1:0] rd_val;

   assign idx = paddr[ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign wbyte = pwdata[7:0];
   // A request is in flight until the oscillator side echoes the toggle back.
   assign busy = (bus_q.req_tgl != ack_sync);
   assign access = psel && penable;
   assign accept = access && bus_q.pready;

   always_comb begin
      mapped = aligned;
      rd_val = '0;
      case (idx)
         IDX_KEY_COMMAND: rd_val = '0;
         IDX_PRESCALE_SELECT: rd_val[PRESCALE_W-1:0] = bus_q.prescale;
         IDX_RELOAD_VALUE: rd_val[RELOAD_W-1:0] = bus_q.reload;
         IDX_STATUS: begin
            rd_val[STAT_RUNNING] = running_sync;
            rd_val[STAT_UNLOCKED] = bus_q.unlocked;
            rd_val[STAT_BUSY] = busy;
            rd_val[STAT_EXPIRED] = expired_sync;
         end
         default: mapped = 1'b0;
      endcase
   end

   // Key writes that reach the counter, and unlocked configuration writes.
   assign key_wr_req = (idx == IDX_KEY_COMMAND) && ((wbyte == KEY_START) ||
                       (wbyte == KEY_REFRESH));
   assign cfg_wr = ((idx == IDX_PRESCALE_SELECT) || (idx == IDX_RELOAD_VALUE)) &&
                   bus_q.unlocked; // [RULE4]
   assign needs_req = pwrite && aligned && (key_wr_req || cfg_wr);

   // ---------------------------------------------------------------
   // Bus domain next state
   // ---------------------------------------------------------------
   always_comb begin
      bus_d = bus_q;
      if (accept) begin
         bus_d.pready = 1'b0;
         bus_d.pslverr = 1'b0;
         bus_d.prdata = '0;
         if (pwrite && mapped) begin
            case (idx)
               IDX_KEY_COMMAND: begin
                  if (wbyte == KEY_START) begin
                     bus_d.req_cmd = CMD_START; // [RULE1]
                     bus_d.req_tgl = !bus_q.req_tgl;
                  end else if (wbyte == KEY_REFRESH) begin
                     bus_d.req_cmd = CMD_REFRESH; // [RULE3]
                     bus_d.req_tgl = !bus_q.req_tgl;
                     bus_d.unlocked = 1'b0; // [RULE5]
                  end else if (wbyte == KEY_UNLOCK) begin
                     bus_d.unlocked = 1'b1; // [RULE4]
                  end
                  // Any other key value leaves everything as it was. [RULE13]
               end
               IDX_PRESCALE_SELECT: begin
                  if (bus_q.unlocked) begin
                     // Upper bits are dropped and read back as zero.
                     bus_d.prescale = wbyte[PRESCALE_W-1:0]; // [RULE4]
                     bus_d.req_cmd = CMD_CONFIG;
                     bus_d.req_tgl = !bus_q.req_tgl;
                  end
               end
               IDX_RELOAD_VALUE: begin
                  if (bus_q.unlocked) begin
                     bus_d.reload = wbyte; // [RULE4]
                     bus_d.req_cmd = CMD_CONFIG;
                     bus_d.req_tgl = !bus_q.req_tgl;
                  end
               end
               default: begin
                  bus_d.req_cmd = bus_q.req_cmd;
               end
            endcase
         end
      end else if (access && !(needs_req && busy)) begin
         // Holding pready low while a request is in flight keeps the
         // crossing words stable until the slow side has taken them.
         bus_d.pready = 1'b1; // [RULE13]
         bus_d.pslverr = !mapped;
         bus_d.prdata = (!pwrite && mapped) ? rd_val : '0;
      end else begin
         bus_d.pready = 1'b0;
         bus_d.pslverr = 1'b0;
         bus_d.prdata = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         bus_q.pready <= 1'b0;
         bus_q.pslverr <= 1'b0;
         bus_q.prdata <= '0;
         bus_q.unlocked <= 1'b0;
         bus_q.req_tgl <= 1'b0;
         bus_q.req_cmd <= CMD_CONFIG;
         bus_q.prescale <= PRESCALE_RST;
         bus_q.reload <= RELOAD_RST;
      end else begin
         bus_q <= bus_d;
      end
   end

   // ---------------------------------------------------------------
   // Oscillator domain: prescaler, down-counter and reset generation
   // ---------------------------------------------------------------
   logic [PRESCALE_W-1:0] code_eff;
   logic [PRE_W-1:0] pre_mask;
   logic tick;
   logic req_new;

   // The reserved code behaves as the longest divider. [RULE7]
   assign code_eff = (osc_q.prescale > PRESCALE_MAX) ? PRESCALE_MAX : osc_q.prescale;
   // A tick every 2^(code+3) oscillator cycles gives /2^(code+2) of the 64 kHz base. [RULE8]
   assign pre_mask = (PRE_ONE << (PRE_W'(code_eff) + PRE_W'(PRE_SHIFT_MIN))) - PRE_ONE;
   assign tick = ((osc_q.pre_cnt & pre_mask) == pre_mask); // [RULE7]
   assign req_new = (req_sync != osc_q.ack_tgl);

   always_comb begin
      osc_d = osc_q;
      osc_d.pre_cnt = osc_q.pre_cnt + PRE_ONE;
      if (!osc_q.strap_done) begin
         // The option level is caught on the first edge after reset release.
         osc_d.strap_done = 1'b1;
         if (hw_autostart_option) begin
            osc_d.st = WD_RUNNING; // [RULE6]
            osc_d.count = COUNT_START;
            osc_d.pre_cnt = PRE_ZERO;
         end
      end else begin
         case (osc_q.st)
            WD_IDLE: begin
               osc_d.pre_cnt = PRE_ZERO;
            end
            WD_RUNNING: begin
               if (tick) begin
                  osc_d.pre_cnt = PRE_ZERO;
                  if (osc_q.count == COUNT_END) begin
                     osc_d.st = WD_EXPIRED; // [RULE2]
                     osc_d.wdg_rst = 1'b1;
                  end else begin
                     osc_d.count = osc_q.count - 8'h01; // [RULE1]
                  end
               end
            end
            WD_EXPIRED: begin
               // Expiry is final until the system reset comes back.
               osc_d.wdg_rst = 1'b1; // [RULE2]
               osc_d.pre_cnt = PRE_ZERO;
            end
            default: begin
               osc_d.st = WD_IDLE;
            end
         endcase
         if (req_new && (osc_q.st != WD_EXPIRED)) begin
            // Bus words are stable while the handshake is open. [RULE13]
            osc_d.ack_tgl = req_sync;
            osc_d.prescale = bus_q.prescale;
            osc_d.reload = bus_q.reload;
            if (bus_q.req_cmd == CMD_START && osc_q.st == WD_IDLE) begin
               osc_d.st = WD_RUNNING; // [RULE1]
               osc_d.count = COUNT_START;
               osc_d.pre_cnt = PRE_ZERO;
            end else if (bus_q.req_cmd == CMD_REFRESH && osc_q.st == WD_RUNNING) begin
               osc_d.count = bus_q.reload; // [RULE3]
               osc_d.pre_cnt = PRE_ZERO;
            end
         end else if (req_new) begin
            osc_d.ack_tgl = req_sync;
         end
      end
   end

   // Only the slow oscillator clocks the counter, so a dead ref_clk cannot stop it. [RULE9]
   always_ff @(posedge low_speed_internal_osc) begin
      if (!osc_rst_n) begin
         osc_q.st <= WD_IDLE;
         osc_q.ack_tgl <= 1'b0;
         osc_q.strap_done <= 1'b0;
         osc_q.pre_cnt <= PRE_ZERO;
         osc_q.count <= COUNT_START;
         osc_q.prescale <= PRESCALE_RST;
         osc_q.reload <= RELOAD_RST;
         osc_q.wdg_rst <= 1'b0;
      end else begin
         osc_q <= osc_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = bus_q.prdata;
   assign pready = bus_q.pready;
   assign pslverr = bus_q.pslverr;
   assign watchdog_reset_out = osc_q.wdg_rst; // [RULE2]

endmodule

/* dv/wdg_chk.sv */
// Purpose: Concurrent checks on the watchdog bus and reset ports.
// Assumes: Every check runs on ref_clk; the oscillator-side output is judged there too.
// Notes:   Bound into every instance of the watchdog.

`timescale 1ns/1ps

module wdg_chk (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic low_speed_internal_osc,
   input wire logic hw_autostart_option,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
   input wire logic [wdg_pkg::DATA_W-1:0] pwdata,
   input wire logic [wdg_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic watchdog_reset_out
);
   import wdg_pkg::*;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_bound: assert property ($rose(penable) |-> ##[1:400] pready)
      else $error("transfer never completed");
   a_read_fast: assert property ($rose(penable) && !pwrite |=> pready)
      else $error("read not answered after one access cycle");
   a_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("error response outside a completing transfer");
   a_bad_addr: assert property (pready && (paddr[1:0] != 2'h0 ||
      paddr[7:2] > IDX_STATUS) |-> pslverr)
      else $error("unmapped access not flagged");
   a_good_addr: assert property (pready && paddr[1:0] == 2'h0 &&
      paddr[7:2] <= IDX_STATUS |-> !pslverr)
      else $error("mapped access flagged as an error");
   a_key_wonly: assert property (pready && !pwrite && paddr == 8'h00 |->
      prdata == 32'h0)
      else $error("key register read back nonzero");
   a_code_width: assert property (pready && !pwrite && paddr == 8'h04 |->
      prdata[31:3] == 29'h0)
      else $error("prescale read wider than three bits");
   a_reload_width: assert property (pready && !pwrite && paddr == 8'h08 |->
      prdata[31:8] == 24'h0)
      else $error("reload read wider than eight bits");
   a_expire_sticky: assert property (watchdog_reset_out |=> watchdog_reset_out)
      else $error("watchdog reset dropped before system reset");
   a_boot_quiet: assert property ($rose(reset_n) |-> !watchdog_reset_out [*4])
      else $error("watchdog reset right after release");
endmodule

bind key_unlocked_independent_watchdog wdg_chk chk (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .low_speed_internal_osc(low_speed_internal_osc),
   .hw_autostart_option(hw_autostart_option),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .watchdog_reset_out(watchdog_reset_out)
);

/* dv/test_key_unlocked_independent_watchdog.sv */
// Purpose: Self-checking bench for the key-unlocked independent watchdog.
// Assumes: The oscillator runs fast in simulation so that timeouts stay short.
// Notes:   Timeout counts are taken in oscillator cycles with a small tolerance for syncing.

`timescale 1ns/1ps

module test_key_unlocked_independent_watchdog;
   import wdg_pkg::*;

   localparam logic [7:0] A_KEY = {IDX_KEY_COMMAND, 2'h0};
   localparam logic [7:0] A_PRE = {IDX_PRESCALE_SELECT, 2'h0};
   localparam logic [7:0] A_RL = {IDX_RELOAD_VALUE, 2'h0};
   localparam logic [7:0] A_STAT = {IDX_STATUS, 2'h0};

   logic ref_clk = 1'h0;
   logic clk_run = 1'h1;
   logic osc = 1'h0;
   logic reset_n = 1'h0;
   logic hw_opt = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rdata;
   logic pready;
   logic pslverr;
   logic rerr;
   logic wdr;
   int err_total = 0;
   int checked = 0;

   // Stopping ref_clk shows the counter does not lean on the bus clock.
   always #5 ref_clk = clk_run ? ~ref_clk : ref_clk;
   always #20.3 osc = ~osc;

   key_unlocked_independent_watchdog uut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .low_speed_internal_osc(osc),
      .hw_autostart_option(hw_opt),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .watchdog_reset_out(wdr)
   );

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("compares %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic fail(input string m);
      $display("ERROR t=%0t %s", $time, m);
      err_total++;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
         fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask

   task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 500);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         fail("bus hang");
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      cmp(rdata, exp, "read");
   endtask

   task automatic do_reset(input logic opt);
      @(posedge ref_clk);
      reset_n <= 1'h0;
      hw_opt <= opt;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'h1;
   endtask

   // Unlock, program both fields, then refresh so the new reload is taken.
   task automatic setup(input logic [2:0] code, input logic [7:0] rl);
      wr(A_KEY, 32'(KEY_UNLOCK));
      wr(A_PRE, 32'(code));
      wr(A_RL, 32'(rl));
      wr(A_KEY, 32'(KEY_REFRESH));
   endtask

   task automatic expire(input int lo, input int hi);
      int n;
      n = 0;
      while (wdr !== 1'h1 && n <= hi) begin
         @(posedge osc);
         n++;
      end
      checked++;
      if (n < lo || n > hi)
         fail($sformatf("expiry after %0d osc cycles", n));
      if (n > hi)
         final_report();
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      do_reset(1'h0);
      rd(A_KEY, 32'h0);
      rd(A_PRE, 32'h0);
      rd(A_RL, 32'hFF);
      rd(A_STAT, 32'h0);
      apb(1'h0, 8'h10, 32'h0);
      cmp(32'(rerr), 32'h1, "unmapped");
      apb(1'h1, 8'h05, 32'h0);
      cmp(32'(rerr), 32'h1, "misaligned");
      $display("test reset values done");
      wr(A_KEY, 32'h12);
      repeat (20) @(posedge osc);
      rd(A_STAT, 32'h0);
      cmp(32'(wdr), 32'h0, "idle reset");
      $display("test stray key done");
      wr(A_KEY, 32'(KEY_START));
      repeat (8) @(posedge osc);
      rd(A_STAT, 32'h1);
      wr(A_RL, 32'h10);
      rd(A_RL, 32'hFF);
      wr(A_PRE, 32'h3);
      rd(A_PRE, 32'h0);
      wr(A_KEY, 32'(KEY_UNLOCK));
      rd(A_STAT, 32'h3);
      wr(A_RL, 32'h10);
      rd(A_RL, 32'h10);
      wr(A_PRE, 32'h2);
      rd(A_PRE, 32'h2);
      wr(A_KEY, 32'(KEY_REFRESH));
      // The refresh crossing is still open here, so the busy bit reads back set.
      rd(A_STAT, 32'h5);
      wr(A_RL, 32'h20);
      rd(A_RL, 32'h10);
      cmp(32'(wdr), 32'h0, "early expiry");
      $display("test lock done");
      setup(3'h0, 8'h03);
      repeat (6) begin
         repeat (20) @(posedge osc);
         wr(A_KEY, 32'(KEY_REFRESH));
      end
      cmp(32'(wdr), 32'h0, "refresh missed");
      expire(28, 36);
      rd(A_STAT, 32'h8);
      $display("test refresh done");
      for (int c = 0; c < 8; c++) begin
         do_reset(1'h0);
         wr(A_KEY, 32'(KEY_START));
         setup(3'(c), 8'h01);
         n = 16 << (c > 6 ? 6 : c);
         clk_run = (c != 0);
         expire(n - 4, n + 4);
         clk_run = 1'h1;
      end
      $display("test prescale codes done");
      do_reset(1'h1);
      repeat (10) @(posedge osc);
      rd(A_STAT, 32'h1);
      setup(3'h0, 8'h01);
      expire(12, 20);
      do_reset(1'h0);
      $display("test auto start done");
      final_report();
   end
endmodule
